//--- hw/rsq_defines.vh
// constants for the reset sequencer and cause status block
`ifndef RSQ_DEFINES_VH
`define RSQ_DEFINES_VH

// apb byte offsets
`define RSQ_OFS_STATUS   12'h000
`define RSQ_OFS_CTRL     12'h004
`define RSQ_OFS_SEQ      12'h008

// reset cause status bit positions, bit 0 unused
`define RSQ_BIT_POR      7
`define RSQ_BIT_PIN      6
`define RSQ_BIT_WDT      5
`define RSQ_BIT_BADOP    4
`define RSQ_BIT_BADFA    3
`define RSQ_BIT_MON      2
`define RSQ_BIT_LOWV     1

// control register bit positions
`define RSQ_BIT_STOP_EN  0
`define RSQ_BIT_WDT_EN   1

// reset values
`define RSQ_RST_STATUS   8'h80
`define RSQ_RST_CTRL     2'h2
`define RSQ_VALID_MASK   8'hfe

// cpu side addresses
`define RSQ_WDT_ADDR     16'hffff
`define RSQ_VECTOR_ADDR  16'hfffe

// timing counts in reference clock cycles
`define RSQ_PIN_CYC      13'h0020
`define RSQ_HOLD_CYC     13'h0020
`define RSQ_OSC_CYC      13'h1000
`define RSQ_EXT_MIN_CYC  8'h10
`define RSQ_WDT_DEFAULT  262143

`endif

//--- hw/rsq_sync.v
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module rsq_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             i_clk_sys,
  input  wire             i_rst,
  // asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= RESET_VAL;
      o_sync   <= RESET_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

//--- hw/rsq_reset_seq.v
// reset sequencer with reset cause status register on apb
//
// Behaviour
// - reset pin held low long enough resets and sets external flag
// - internal resets drive pin low 32 cycles, then hold core 32 more
// - any reset aborts current instruction; core fetches vector at top
// - reset selects reference clock divided by four as bus clock
// - power-on stops clocks and drives pin low for 4096 cycles
// - after stabilisation: pin released 32 later, vector fetch 64 later
// - power-on sets power-on flag and clears all other flags
// - low supply drives pin low; clocks stay stopped 4096 after recovery
// - low supply flag set when low supply sequence completes
// - watchdog overflow resets and sets watchdog flag
// - write to watchdog location restarts counter without reset
// - undefined opcode resets and sets bad opcode flag
// - stop with stop enable clear counts as undefined opcode
// - opcode fetch from unmapped address resets, sets bad fetch flag
// - data access to unmapped address never resets
// - status register read only; a read or power-on clears flags, nothing else does
// - flags of several resets accumulate until a read
// - pin sampled 32 cycles after release; low sets external flag
// - forced monitor entry reset sets monitor entry flag
`timescale 1ns/100ps
`include "rsq_defines.vh"
module rsq_reset_seq #(
  parameter WDT_CYCLES = `RSQ_WDT_DEFAULT
) (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg         o_pready,
  output reg  [31:0] o_prdata,
  output reg         o_pslverr,
  // reset pin, open drain
  input  wire        i_rst_pin_in,
  output reg         o_rst_pin_out,
  output reg         o_rst_pin_oe,
  // analog detector levels
  input  wire        i_por_req,
  input  wire        i_supply_low,
  // cpu events, same clock
  input  wire        i_cpu_wr,
  input  wire [15:0] i_cpu_addr,
  input  wire        i_cpu_illegal_op,
  input  wire        i_cpu_stop_op,
  input  wire        i_cpu_fetch,
  input  wire        i_cpu_unmapped,
  input  wire        i_mon_entry_req,
  // core and clock control
  output reg         o_core_rst,
  output reg         o_clk_stop,
  output reg         o_bus_clk_div4,
  output reg         o_vec_fetch,
  output reg  [15:0] o_vec_addr
);

  // sequencer states
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_EXT   = 3'h1;
  localparam [2:0] ST_LOWV  = 3'h2;
  localparam [2:0] ST_OSC   = 3'h3;
  localparam [2:0] ST_DRIVE = 3'h4;
  localparam [2:0] ST_HOLD  = 3'h5;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [12:0] cnt_reg;
  reg  [12:0] cnt_next;
  reg  [7:0]  ext_cnt_reg;
  reg  [7:0]  ext_cnt_next;
  reg  [17:0] wdt_reg;
  reg  [17:0] wdt_next;
  reg  [7:0]  status_reg;
  reg  [7:0]  status_next;
  reg  [7:0]  set_vec;
  reg  [1:0]  ctrl_reg;
  reg  [1:0]  ctrl_next;
  reg         lowv_pend_reg;
  reg         lowv_pend_next;
  reg         int_path_reg;
  reg         int_path_next;
  reg         por_evt;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  wire [2:0]  sync_out;
  wire        pin_s;
  wire        por_s;
  wire        supply_s;
  wire        apb_setup;
  wire        apb_done;
  wire        wr_ctrl;
  wire        rd_status;
  wire        wdt_kick;
  wire        wdt_ovf;
  wire        badop_evt;
  wire        badfa_evt;
  wire [31:0] wdt_wide;

  // pin and analog levels come from other domains
  rsq_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h1)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_supply_low, i_por_req, i_rst_pin_in}),
    .o_sync    (sync_out)
  );

  assign pin_s = sync_out[0];
  assign por_s = sync_out[1];
  assign supply_s = sync_out[2];

  // apb phases; pready is registered so every access takes two cycles
  assign apb_setup = i_psel & i_penable & ~o_pready;
  assign apb_done  = i_psel & i_penable & o_pready;
  assign wr_ctrl   = apb_done & i_pwrite & (i_paddr == `RSQ_OFS_CTRL);
  assign rd_status = apb_done & ~i_pwrite & (i_paddr == `RSQ_OFS_STATUS);

  // cpu side events
  assign wdt_kick = i_cpu_wr & (i_cpu_addr == `RSQ_WDT_ADDR);
  assign wdt_wide = {14'h0000, wdt_reg};
  assign wdt_ovf  = ctrl_reg[`RSQ_BIT_WDT_EN] &
                    (wdt_wide == WDT_CYCLES - 1);
  assign badop_evt = i_cpu_illegal_op |
                     (i_cpu_stop_op &
                      ~ctrl_reg[`RSQ_BIT_STOP_EN]);
  // only opcode fetches count; data accesses are masked out by i_cpu_fetch
  assign badfa_evt = i_cpu_fetch & i_cpu_unmapped;

  // register read mux, unused status bit 0 forced low
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (i_paddr)
      `RSQ_OFS_STATUS: begin
        rd_mux[7:0] = status_reg & `RSQ_VALID_MASK;
      end
      `RSQ_OFS_CTRL: begin
        rd_mux[1:0] = ctrl_reg;
      end
      `RSQ_OFS_SEQ: begin
        rd_mux[2:0] = state_reg;
        rd_mux[3]   = pin_s;
        rd_mux[4]   = lowv_pend_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // sequencer next state; power-on beats low supply beats the rest
  always @* begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    ext_cnt_next  = 8'h00;
    lowv_pend_next = lowv_pend_reg;
    int_path_next = int_path_reg;
    set_vec       = 8'h00;
    por_evt       = 1'b0;
    if (por_s) begin
      // held in stabilisation until the detector lets go
      por_evt       = 1'b1;
      state_next    = ST_OSC;
      cnt_next      = 13'h0000;
      lowv_pend_next = 1'b0;
      int_path_next = 1'b1;
    end else if (supply_s) begin
      state_next    = ST_LOWV;
      cnt_next      = 13'h0000;
      lowv_pend_next = 1'b1;
      int_path_next = 1'b1;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (wdt_ovf | badop_evt | badfa_evt | i_mon_entry_req) begin
            // abort at once; several causes in one cycle all flag
            set_vec[`RSQ_BIT_WDT]   = wdt_ovf;
            set_vec[`RSQ_BIT_BADOP] = badop_evt;
            set_vec[`RSQ_BIT_BADFA] = badfa_evt;
            set_vec[`RSQ_BIT_MON]  = i_mon_entry_req;
            state_next    = ST_DRIVE;
            cnt_next      = 13'h0000;
            int_path_next = 1'b1;
          end else if (!pin_s) begin
            // pin must stay low for the minimum width first
            ext_cnt_next = ext_cnt_reg + 8'h01;
            if (ext_cnt_reg == `RSQ_EXT_MIN_CYC - 8'h01) begin
              set_vec[`RSQ_BIT_PIN] = 1'b1;
              state_next    = ST_EXT;
              int_path_next = 1'b0;
            end
          end
        end
        ST_EXT: begin
          // core held while the outside party keeps the pin low
          if (pin_s) begin
            state_next = ST_HOLD;
            cnt_next   = 13'h0000;
          end
        end
        ST_LOWV: begin
          // supply is back once the detector level drops
          state_next = ST_OSC;
          cnt_next   = 13'h0000;
        end
        ST_OSC: begin
          cnt_next = cnt_reg + 13'h0001;
          if (cnt_reg == `RSQ_OSC_CYC - 13'h0001) begin
            state_next = ST_DRIVE;
            cnt_next   = 13'h0000;
          end
        end
        ST_DRIVE: begin
          cnt_next = cnt_reg + 13'h0001;
          if (cnt_reg == `RSQ_PIN_CYC - 13'h0001) begin
            state_next = ST_HOLD;
            cnt_next   = 13'h0000;
          end
        end
        ST_HOLD: begin
          cnt_next = cnt_reg + 13'h0001;
          if (cnt_reg == `RSQ_HOLD_CYC - 13'h0001) begin
            state_next = ST_RUN;
            cnt_next   = 13'h0000;
            // pin checked 32 cycles after our own release
            if (int_path_reg && !pin_s) begin
              set_vec[`RSQ_BIT_PIN] = 1'b1;
            end
            if (lowv_pend_reg) begin
              set_vec[`RSQ_BIT_LOWV] = 1'b1;
              lowv_pend_next         = 1'b0;
            end
          end
        end
        default: begin
          state_next = ST_OSC;
          cnt_next   = 13'h0000;
        end
      endcase
    end
  end

  // status flags: a read clears only what it returned, so a cause that
  // lands between the sample and the clear survives; sets win
  always @* begin
    status_next = status_reg;
    if (rd_status) begin
      status_next = status_reg & ~o_prdata[7:0];
    end
    status_next = (status_next | set_vec) & `RSQ_VALID_MASK;
    if (por_evt) begin
      status_next = `RSQ_RST_STATUS;
    end
  end

  // control register write
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = i_pwdata[1:0];
    end
  end

  // watchdog counts only while the core runs
  always @* begin
    wdt_next = wdt_reg + 18'h00001;
    if ((state_reg != ST_RUN) || wdt_kick || wdt_ovf ||
        !ctrl_reg[`RSQ_BIT_WDT_EN]) begin
      wdt_next = 18'h00000;
    end
  end

  // sequencer and flag registers; power-up starts stabilisation
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg    <= ST_OSC;
      cnt_reg      <= 13'h0000;
      ext_cnt_reg  <= 8'h00;
      wdt_reg      <= 18'h00000;
      status_reg   <= `RSQ_RST_STATUS;
      ctrl_reg     <= `RSQ_RST_CTRL;
      lowv_pend_reg <= 1'b0;
      int_path_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      ext_cnt_reg  <= ext_cnt_next;
      wdt_reg      <= wdt_next;
      status_reg   <= status_next;
      ctrl_reg     <= ctrl_next;
      lowv_pend_reg <= lowv_pend_next;
      int_path_reg <= int_path_next;
    end
  end

  // core, clock and pin outputs, all registered; levels from the next state, vector fetch from the step into run
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_core_rst     <= 1'b1;
      o_clk_stop     <= 1'b1;
      o_bus_clk_div4 <= 1'b1;
      o_vec_fetch    <= 1'b0;
      o_vec_addr     <= `RSQ_VECTOR_ADDR;
      o_rst_pin_out  <= 1'b0;
      o_rst_pin_oe   <= 1'b1;
    end else begin
      o_core_rst     <= (state_next != ST_RUN);
      o_clk_stop     <= (state_next == ST_OSC) ||
                        (state_next == ST_LOWV);
      // left selected once running; no control register bit clears it
      if (state_next != ST_RUN) begin
        o_bus_clk_div4 <= 1'b1;
      end
      o_vec_fetch    <= (state_reg != ST_RUN) &&
                        (state_next == ST_RUN);
      o_vec_addr     <= `RSQ_VECTOR_ADDR;
      o_rst_pin_out  <= 1'b0;
      o_rst_pin_oe   <= (state_next == ST_OSC) ||
                        (state_next == ST_LOWV) ||
                        (state_next == ST_DRIVE);
    end
  end

  // apb answer registered one cycle into the access phase
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_setup;
      if (apb_setup) begin
        o_prdata  <= i_pwrite ? 32'h00000000 : rd_mux;
        // status is read only, writes to it are refused
        o_pslverr <= ~rd_hit |
                     (i_pwrite & (i_paddr == `RSQ_OFS_STATUS));
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

endmodule

//--- sim/rsq_reset_seq_props.sv
// port assertions for the reset sequencer
`timescale 1ns/100ps
module rsq_reset_seq_chk #(
  parameter WDT_CYCLES = 64
) (
  input wire        i_clk_sys,
  input wire        i_rst,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire        i_supply_low,
  input wire        i_cpu_illegal_op,
  input wire        i_cpu_fetch,
  input wire        i_cpu_unmapped,
  input wire        i_mon_entry_req,
  input wire        o_pready,
  input wire [31:0] o_prdata,
  input wire        o_rst_pin_oe,
  input wire        o_core_rst,
  input wire        o_clk_stop,
  input wire        o_bus_clk_div4,
  input wire        o_vec_fetch,
  input wire [15:0] o_vec_addr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  reg [12:0] drv_cnt_reg;
  reg [12:0] stop_cnt_reg;
  // run lengths; the stop count skips low supply, whose length is external
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      drv_cnt_reg  <= 13'h0;
      stop_cnt_reg <= 13'h0;
    end else begin
      drv_cnt_reg  <= (o_rst_pin_oe && !o_clk_stop) ?
                      drv_cnt_reg + 13'h1 : 13'h0;
      stop_cnt_reg <= (o_clk_stop && !i_supply_low) ?
                      stop_cnt_reg + 13'h1 : 13'h0;
    end
  end
  AST_PIN_DRIVE_32: assert property (
    $fell(o_rst_pin_oe) |-> drv_cnt_reg == 13'h20)
    else $error("pin driven low for a wrong number of cycles");
  AST_HOLD_32: assert property (
    $fell(o_rst_pin_oe) |-> o_core_rst[*8] ##25 (o_vec_fetch && !o_core_rst))
    else $error("core hold after pin release has wrong length");
  // the synchroniser on the supply level adds a few cycles of slack
  AST_OSC_4096: assert property (
    $fell(o_clk_stop) |-> stop_cnt_reg inside {[13'hfff:13'h1004]})
    else $error("stabilisation delay has wrong length");
  AST_VEC_ADDR: assert property (
    o_vec_fetch |-> o_vec_addr == 16'hfffe)
    else $error("vector fetch from wrong address");
  AST_DIV4: assert property (
    o_core_rst |-> o_bus_clk_div4)
    else $error("bus clock not ref over four in reset");
  AST_VEC_PULSE: assert property (
    $rose(o_vec_fetch) |-> $fell(o_core_rst) ##1 !o_vec_fetch)
    else $error("vector fetch not a single release pulse");
  AST_EVENT_RESET: assert property (
    (!o_core_rst && (i_cpu_illegal_op || i_mon_entry_req ||
     (i_cpu_fetch && i_cpu_unmapped))) |=> o_core_rst && o_rst_pin_oe)
    else $error("cpu event did not reset at once");
  AST_CLK_CORE: assert property (
    o_clk_stop |-> o_core_rst)
    else $error("clocks stopped while core runs");
  AST_SPARE_ZERO: assert property (
    (o_pready && !i_pwrite && i_paddr == 12'h000) |->
      (o_prdata[0] == 1'b0 && o_prdata[31:8] == 24'h0))
    else $error("unused status bits not zero");
  COV_VEC: cover property ($rose(o_vec_fetch));
  COV_OSC: cover property ($fell(o_clk_stop));
  COV_DRV: cover property ($fell(o_rst_pin_oe));
endmodule
bind rsq_reset_seq rsq_reset_seq_chk #(.WDT_CYCLES(WDT_CYCLES)) u_chk (
  .i_clk_sys, .i_rst, .i_pwrite, .i_paddr, .i_supply_low, .i_cpu_illegal_op,
  .i_cpu_fetch, .i_cpu_unmapped, .i_mon_entry_req, .o_pready, .o_prdata,
  .o_rst_pin_oe, .o_core_rst, .o_clk_stop, .o_bus_clk_div4, .o_vec_fetch,
  .o_vec_addr);

//--- sim/rsq_pin_model.sv
// reset line shared with an external device, pulled up when released
`timescale 1ns/100ps
module rsq_pin_model (
  // design side of the open-drain pin
  input  wire i_pin_out,
  input  wire i_pin_oe,
  // external device pulling the line low, for as long as it likes
  input  wire i_ext_pull,
  // resolved line level
  output wire o_pin_level
);
  // wired-and: a released line floats back high through the pull-up
  assign o_pin_level = (i_pin_oe ? i_pin_out : 1'b1) &
                       ~i_ext_pull;
endmodule

//--- sim/rsq_reset_seq_tb.sv
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module rsq_reset_seq_tb;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, xpull = 1'b0, por = 1'b0, slow = 1'b0;
  logic        cwr = 1'b0;
  logic [11:0] padr = 12'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        prdy, perr, er, pout, poe, plvl, crst, cstop, div4, vec;
  logic [4:0]  ev = 5'h0; // illegal, stop, fetch, unmapped, monitor
  logic [15:0] vadr, cadr = 16'hffff;
  int          num_errors = 0, checks = 0, cyc = 0;
  rsq_reset_seq #(.WDT_CYCLES(64)) rsq_reset_seq_inst (
    .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_pready(prdy),
    .o_prdata(prd), .o_pslverr(perr), .i_rst_pin_in(plvl),
    .o_rst_pin_out(pout), .o_rst_pin_oe(poe), .i_por_req(por),
    .i_supply_low(slow), .i_cpu_wr(cwr), .i_cpu_addr(cadr),
    .i_cpu_illegal_op(ev[4]), .i_cpu_stop_op(ev[3]),
    .i_cpu_fetch(ev[2]), .i_cpu_unmapped(ev[1]),
    .i_mon_entry_req(ev[0]), .o_core_rst(crst), .o_clk_stop(cstop),
    .o_bus_clk_div4(div4), .o_vec_fetch(vec), .o_vec_addr(vadr));
  rsq_pin_model rsq_pin_model_inst (.i_pin_out(pout), .i_pin_oe(poe),
    .i_ext_pull(xpull), .o_pin_level(plvl));
  always #5 clk = ~clk;
  // background watchdog kicks every 16 cycles, plus the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cwr <= (cyc[3:0] == 4'h0);
    if (cyc == 30000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no wait count here: only the bench timeout ends a stuck transfer
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rs(input logic [7:0] e, input string m);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, {24'h0, e}, m);
  endtask
  task automatic wv();
    int n;
    n = 0;
    while (vec !== 1'b1 && n++ < 6000) @(posedge clk);
    chk({31'h0, vec}, 32'h1, "no vector fetch");
    @(posedge clk);
  endtask
  task automatic fire(input logic [4:0] v, input logic q);
    ev <= v;
    @(posedge clk);
    ev <= 5'h0;
    if (q) begin
      repeat (5) @(posedge clk);
      chk({31'h0, crst}, 32'h0, "unexpected reset");
    end else
      wv();
  endtask
  task automatic t_boot();
    wv();
    rs(8'h80, "power-up status");
    apb(1'b1, 12'h000, 32'hff);
    chk({31'h0, er}, 32'h1, "status write accepted");
    rs(8'h00, "status not cleared");
    $display("boot done");
  endtask
  task automatic t_wdt();
    repeat (200) @(posedge clk);
    rs(8'h00, "kicked watchdog fired");
    // kicks now land one address below the watchdog location
    cadr <= 16'hfffe;
    wv();
    cadr <= 16'hffff;
    rs(8'h20, "watchdog flag");
    $display("watchdog done");
  endtask
  task automatic t_cpu();
    fire(5'h10, 1'b0);
    rs(8'h10, "bad opcode flag");
    fire(5'h08, 1'b0);
    fire(5'h06, 1'b0);
    rs(8'h18, "stacked flags");
    fire(5'h01, 1'b0);
    rs(8'h04, "monitor flag");
    fire(5'h02, 1'b1);
    apb(1'b1, 12'h004, 32'h3);
    fire(5'h08, 1'b1);
    $display("cpu events done");
  endtask
  task automatic t_ext();
    xpull <= 1'b1;
    repeat (30) @(posedge clk);
    chk({31'h0, crst}, 32'h1, "pin reset not taken");
    repeat (10) @(posedge clk);
    xpull <= 1'b0;
    wv();
    rs(8'h40, "pin flag");
    // pin still held low when our own release is sampled
    xpull <= 1'b1;
    fire(5'h01, 1'b0);
    xpull <= 1'b0;
    rs(8'h44, "pin low after own reset");
    $display("external pin done");
  endtask
  task automatic t_supply();
    slow <= 1'b1;
    repeat (20) @(posedge clk);
    chk({30'h0, poe, cstop}, 32'h3, "low supply not held");
    slow <= 1'b0;
    wv();
    rs(8'h02, "low supply flag");
    $display("low supply done");
  endtask
  task automatic t_por();
    fire(5'h01, 1'b0);
    por <= 1'b1;
    repeat (5) @(posedge clk);
    por <= 1'b0;
    wv();
    rs(8'h80, "power-on clears others");
    $display("power-on done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_boot();
    t_wdt();
    t_cpu();
    t_ext();
    t_supply();
    t_por();
    final_report();
  end
endmodule
